// [design/pcr_pkg.sv]
// Constants, widths and state codes of the phase current readout logic.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package pcr_pkg;

   // ==========================================================
   // Clock
   // ==========================================================
   localparam int CLK_PERIOD_NS = 20;

   // ==========================================================
   // Timing
   // ==========================================================
   // Debounce is a least time, so it rounds up to whole cycles.
   localparam int FAULT_DEBOUNCE_TIME_NS = 3500;
   localparam int FAULT_DEBOUNCE_CYC_I = (FAULT_DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // The clear pulse is a longest time, so it rounds down.
   localparam int FAULT_CLEAR_PULSE_TIME_NS = 500;
   localparam int FAULT_CLEAR_CYC_I = FAULT_CLEAR_PULSE_TIME_NS / CLK_PERIOD_NS;

   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] FAULT_DEBOUNCE_CYC = CNT_W'(FAULT_DEBOUNCE_CYC_I);
   localparam logic [CNT_W-1:0] FAULT_CLEAR_CYC = CNT_W'(FAULT_CLEAR_CYC_I);

   // ==========================================================
   // Duty encoding, in permille of a half period
   // ==========================================================
   localparam int VIN_W = 10;
   localparam int PML_W = 10;
   localparam int PER_W = 14;
   localparam logic [PML_W-1:0] DUTY_ZERO_PML = 10'h0c8;
   localparam logic [PML_W-1:0] DUTY_MIN_PML = 10'h064;
   localparam logic [PML_W-1:0] DUTY_MAX_PML = 10'h12c;
   localparam logic [PML_W-1:0] PML_FULL = 10'h3e8;
   // Gain of 40 %/V is 0.4 permille per mV, written as 2/5.
   localparam int GAIN_NUM = 2;
   localparam int GAIN_DEN = 5;

   // ==========================================================
   // Sample buffer
   // ==========================================================
   localparam int FIFO_DEPTH = 4;
   localparam int WORD_W = PER_W + 1;
   localparam logic [PER_W-1:0] PER_RESET = 14'h0001;

   // ==========================================================
   // Output generator states
   // ==========================================================
   typedef enum logic [2:0]
   {
      GEN_IDLE = 3'b001,
      GEN_RELEASE = 3'b010,
      GEN_DRIVE = 3'b100
   } pcr_gen_t;

endpackage : pcr_pkg

// [design/pcr_fifo.sv]
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the same clock as the buffer.
`timescale 1ns/1ns
module pcr_fifo
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 4
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Filling side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Draining side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // ==========================================================
   // Storage
   // ==========================================================
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   // ==========================================================
   // Pointers and fill level
   // ==========================================================
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : pcr_fifo

// [design/pcr_phase_current_readout.sv]
// Digital readout and protection logic of a shunt phase current sensor.
// Assumes the front end delivers the sensed value as a signed mV code on this
// clock and the overcurrent decision as an asynchronous level; the sync and
// sample pins come straight from the board.
//
// Behaviour
// - Sync edges are the only timing source for sampling and output halves.
// - Sample output is active low, only driven low or released.
// - Released time in half n+1 equals duty of half n times its length.
// - Duty stays between 10% and 30%; zero input gives 20%.
// - Duty is 20% minus 40 %/V times the differential input.
// - Sync high halves are channel 1, sync low halves channel 2.
// - Each half is encoded on its own length, correcting sync asymmetry.
// - Overcurrent lasting past the debounce time latches the fault output low.
// - Debounce lies between 2.7 and 4.7 us, typically 3.5 us.
// - Fault clears only when sample output is held low externally long enough.
// - Clearing never needs a low pulse longer than 0.5 us.
// - While faulted, the sample output stays released.
// - Fault cleared with overcurrent still present returns at next sync edge.
// - Input stage period is derived from sync; integrator resets per period.
// - Front end result is sampled at each sync edge after the first, once per half.
// - A quarter-shifted sync adds a quarter period of latency outside this logic.
`timescale 1ns/1ns
module pcr_phase_current_readout
   import pcr_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Sync pin from the controller
   input wire logic sync_edge_aligned_in,
   // Front end results
   input wire logic overcurrent_in,
   input wire logic signed [VIN_W-1:0] differential_sense_input_in,
   // Open-drain sample pin
   input wire logic duty_sample_pin_in,
   output logic duty_sample_out_n_out,
   output logic duty_sample_oe_out,
   // Open-drain fault pin
   output logic fault_out_n_out,
   output logic fault_oe_out,
   // Channel of the half now being sent, high for channel 1
   output logic sample_channel_out
);

   // ==========================================================
   // Functions
   // ==========================================================
   // Duty in permille for a signed mV input, clamped to the legal span.
   function automatic logic [PML_W-1:0] duty_pml(input logic signed [VIN_W-1:0] mv);
      logic signed [PML_W+2:0] raw;
      raw = (PML_W+3)'(signed'({1'b0, DUTY_ZERO_PML}))
            - (PML_W+3)'((mv * GAIN_NUM) / GAIN_DEN);
      if (raw < (PML_W+3)'(signed'({1'b0, DUTY_MIN_PML})))
      begin
         duty_pml = DUTY_MIN_PML;
      end
      else if (raw > (PML_W+3)'(signed'({1'b0, DUTY_MAX_PML})))
      begin
         duty_pml = DUTY_MAX_PML;
      end
      else
      begin
         duty_pml = raw[PML_W-1:0];
      end
   endfunction : duty_pml

   // Released cycles for a half period of a given length.
   function automatic logic [PER_W-1:0] off_cycles(input logic [PER_W-1:0] per,
                                                   input logic [PML_W-1:0] pml);
      logic [PER_W+PML_W-1:0] prod;
      prod = per * pml;
      off_cycles = PER_W'(prod / PML_FULL);
   endfunction : off_cycles

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Bits are sync, overcurrent and sample pin read-back.
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [2:0] pin_lvl_q;
   logic sync_lvl;
   logic oc_lvl;
   logic pin_lvl;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pin_s1_q <= 3'h4;
         pin_s2_q <= 3'h4;
         pin_s3_q <= 3'h4;
         pin_lvl_q <= 3'h4;
      end
      else
      begin
         pin_s1_q <= {duty_sample_pin_in, overcurrent_in, sync_edge_aligned_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         // A level changes only once the last two stages agree.
         pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
      end
   end

   assign sync_lvl = pin_lvl_q[0];
   assign oc_lvl = pin_lvl_q[1];
   assign pin_lvl = pin_lvl_q[2];

   // ==========================================================
   // Sync edges and half-period measurement
   // ==========================================================
   logic sync_prev_q;
   logic sync_edge;
   logic per_ok_q;
   logic [PER_W-1:0] per_cnt_q;

   assign sync_edge = (sync_lvl != sync_prev_q);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         sync_prev_q <= 1'b0;
         per_ok_q <= 1'b0;
         per_cnt_q <= PER_RESET;
      end
      else
      begin
         sync_prev_q <= sync_lvl;
         if (sync_edge)
         begin
            // The first edge ends a partial half, so its length is not used.
            per_ok_q <= 1'b1;
            per_cnt_q <= PER_RESET;
         end
         else if (per_cnt_q != '1)
         begin
            per_cnt_q <= per_cnt_q + 1'b1;
         end
      end
   end

   // ==========================================================
   // Per-half sampling into the buffer
   // ==========================================================
   logic pend_valid_q;
   logic [WORD_W-1:0] pend_word_q;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pend_valid_q <= 1'b0;
         pend_word_q <= '0;
      end
      else if (sync_edge && per_ok_q)
      begin
         // Channel is the level of the half just ended, length is its own.
         pend_valid_q <= 1'b1;
         pend_word_q <= {sync_prev_q,
                         off_cycles(per_cnt_q, duty_pml(differential_sense_input_in))};
      end
      else if (fifo_in_ready)
      begin
         pend_valid_q <= 1'b0;
      end
   end

   pcr_fifo
   #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(pend_valid_q),
      .in_ready_out(fifo_in_ready),
      .in_data_in(pend_word_q),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );

   // ==========================================================
   // Output generator
   // ==========================================================
   pcr_gen_t gen_q;
   logic [PER_W-1:0] off_cnt_q;
   logic chan_q;
   logic fault_q;

   // A new half is taken only once the released part of the last has ended.
   assign fifo_out_ready = (gen_q != GEN_RELEASE);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         gen_q <= GEN_IDLE;
         off_cnt_q <= '0;
         chan_q <= 1'b0;
      end
      else if (fifo_out_valid && fifo_out_ready)
      begin
         chan_q <= fifo_out_data[WORD_W-1];
         off_cnt_q <= fifo_out_data[PER_W-1:0];
         gen_q <= (fifo_out_data[PER_W-1:0] == '0) ? GEN_DRIVE : GEN_RELEASE;
      end
      else
      begin
         case (gen_q)
            GEN_IDLE:
            begin
               gen_q <= GEN_IDLE;
            end
            GEN_RELEASE:
            begin
               if (off_cnt_q <= PER_RESET)
               begin
                  gen_q <= GEN_DRIVE;
               end
               off_cnt_q <= off_cnt_q - 1'b1;
            end
            GEN_DRIVE:
            begin
               gen_q <= GEN_DRIVE;
            end
            default:
            begin
               gen_q <= GEN_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Overcurrent debounce
   // ==========================================================
   logic [CNT_W-1:0] deb_cnt_q;
   logic rearm_q;
   logic deb_done;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         deb_cnt_q <= '0;
      end
      else if (!oc_lvl || fault_q || rearm_q)
      begin
         deb_cnt_q <= '0;
      end
      else if (deb_cnt_q != FAULT_DEBOUNCE_CYC)
      begin
         deb_cnt_q <= deb_cnt_q + 1'b1;
      end
   end

   assign deb_done = oc_lvl && !fault_q && !rearm_q && (deb_cnt_q == FAULT_DEBOUNCE_CYC);

   // ==========================================================
   // Fault clear by an external low on the sample pin
   // ==========================================================
   logic [CNT_W-1:0] clr_cnt_q;
   logic clr_done;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         clr_cnt_q <= '0;
      end
      else if (!fault_q || pin_lvl || duty_sample_oe_out)
      begin
         // Only a low that this block is not making itself is counted.
         clr_cnt_q <= '0;
      end
      else if (clr_cnt_q != FAULT_CLEAR_CYC)
      begin
         clr_cnt_q <= clr_cnt_q + 1'b1;
      end
   end

   assign clr_done = fault_q && (clr_cnt_q == FAULT_CLEAR_CYC);

   // ==========================================================
   // Fault latch
   // ==========================================================
   logic rearm_set;

   // After a clear with overcurrent still present, the next sync edge trips.
   assign rearm_set = rearm_q && sync_edge && oc_lvl;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         fault_q <= 1'b0;
      end
      else if (deb_done || rearm_set)
      begin
         fault_q <= 1'b1;
      end
      else if (clr_done)
      begin
         fault_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rearm_q <= 1'b0;
      end
      else if (clr_done)
      begin
         rearm_q <= 1'b1;
      end
      else if (sync_edge)
      begin
         rearm_q <= 1'b0;
      end
   end

   // ==========================================================
   // Pin drivers
   // ==========================================================
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         duty_sample_out_n_out <= 1'b1;
         duty_sample_oe_out <= 1'b0;
         fault_out_n_out <= 1'b1;
         fault_oe_out <= 1'b0;
         sample_channel_out <= 1'b0;
      end
      else
      begin
         // Open drain: the value is low whenever the pin is driven.
         duty_sample_out_n_out <= !((gen_q == GEN_DRIVE) && !fault_q);
         duty_sample_oe_out <= (gen_q == GEN_DRIVE) && !fault_q;
         fault_out_n_out <= !fault_q;
         fault_oe_out <= fault_q;
         sample_channel_out <= chan_q;
      end
   end

endmodule : pcr_phase_current_readout

// [tb/pcr_ctrl_model.sv]
// Controller model: makes the sync pin and pulls the sample wire up.
// Assumes the bench sets the half lengths and the external low pull.
`timescale 1ns/1ns
module pcr_ctrl_model
(
   // Clock
   input wire logic clk_in,
   // Bench controls
   input wire logic [13:0] hi_len_in,
   input wire logic [13:0] lo_len_in,
   input wire logic pull_low_in,
   input wire logic tie_in,
   // Device side
   input wire logic dut_oe_in,
   input wire logic fault_oe_in,
   output logic sync_out,
   output logic pin_out
);
   int cnt = 0;
   initial sync_out = 1'b0;
   always @(posedge clk_in)
   begin
      cnt <= cnt + 1;
      if (cnt + 1 >= int'(sync_out ? hi_len_in : lo_len_in))
      begin
         cnt <= 0;
         sync_out <= !sync_out;
      end
   end
   // The pull-up defines high unless a party drives the wire low.
   // With the tie set, the fault pin shares the wire and clears itself.
   assign pin_out = !(dut_oe_in || pull_low_in || (tie_in && fault_oe_in));
endmodule : pcr_ctrl_model

// [tb/pcr_readout_sva.sv]
// Checker on the ports of the phase current readout.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ns
module pcr_readout_sva
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Pins
   input wire logic sync_edge_aligned_in,
   input wire logic overcurrent_in,
   input wire logic duty_sample_pin_in,
   input wire logic duty_sample_out_n_out,
   input wire logic duty_sample_oe_out,
   input wire logic fault_out_n_out,
   input wire logic fault_oe_out,
   input wire logic sample_channel_out
);
   // ====================
   // Helper counters
   // ====================
   int oc_run;
   int low_run;
   int low_best;
   int since_sync;
   logic cleared_q;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !overcurrent_in) oc_run <= 0;
      else if (oc_run < 1000) oc_run <= oc_run + 1;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in || duty_sample_pin_in || duty_sample_oe_out) low_run <= 0;
      else if (low_run < 1000) low_run <= low_run + 1;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !fault_oe_out) low_best <= 0;
      else if (low_run > low_best) low_best <= low_run;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in) since_sync <= 100;
      else if ($changed(sync_edge_aligned_in)) since_sync <= 0;
      else if (since_sync < 100) since_sync <= since_sync + 1;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !overcurrent_in) cleared_q <= 1'b0;
      else if ($fell(fault_oe_out)) cleared_q <= 1'b1;
   end
   // ====================
   // Properties
   // ====================
   sequence s_clear_edge;
      cleared_q && overcurrent_in && !fault_oe_out && $changed(sync_edge_aligned_in);
   endsequence
   sequence s_fault_back;
      ##[3:8] fault_oe_out;
   endsequence
   a_pins_od: assert property (duty_sample_out_n_out == !duty_sample_oe_out && fault_out_n_out == !fault_oe_out)
      else $error("pin value disagrees with its enable");
   a_fault_quiet: assert property (fault_oe_out |-> !duty_sample_oe_out)
      else $error("sample pin driven during fault");
   a_debounce_min: assert property ($rose(fault_oe_out) |-> oc_run >= 175)
      else $error("fault set before debounce");
   a_debounce_max: assert property (oc_run == 190 |-> fault_oe_out)
      else $error("fault late after debounce");
   a_clear_min: assert property ($fell(fault_oe_out) |-> low_best >= 25)
      else $error("fault cleared by too short a pulse");
   a_clear_fast: assert property (low_run == 34 |-> !fault_oe_out)
      else $error("fault not cleared by long pulse");
   a_fault_back: assert property (s_clear_edge |-> s_fault_back)
      else $error("fault not back at sync edge");
   a_chan_follow: assert property ($changed(sample_channel_out) |-> sample_channel_out != sync_edge_aligned_in)
      else $error("channel not the ended half");
   a_release_time: assert property ($fell(duty_sample_oe_out) && !fault_oe_out |-> since_sync inside {[5:11]})
      else $error("release not tied to sync edge");
endmodule : pcr_readout_sva
bind pcr_phase_current_readout pcr_readout_sva i_sva (.clk_in(clk_in), .rst_in(rst_in),
   .sync_edge_aligned_in(sync_edge_aligned_in), .overcurrent_in(overcurrent_in),
   .duty_sample_pin_in(duty_sample_pin_in), .duty_sample_out_n_out(duty_sample_out_n_out),
   .duty_sample_oe_out(duty_sample_oe_out), .fault_out_n_out(fault_out_n_out),
   .fault_oe_out(fault_oe_out), .sample_channel_out(sample_channel_out));

// [tb/tb_pcr_phase_current_readout.sv]
// Bench of the phase current readout against a controller model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ns
module tb_pcr_phase_current_readout
   import pcr_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic oc = 1'b0;
   logic pull_low = 1'b0;
   logic tie = 1'b0;
   logic signed [VIN_W-1:0] mv = '0;
   logic [13:0] hi_len = 14'h03e8;
   logic [13:0] lo_len = 14'h05dc;
   logic sync, pin, s_n, s_oe, f_n, f_oe, chan;
   int err_count = 0;
   int checks_done = 0;
   int mvs[7] = '{0, 250, -250, 400, -400, -3, 100};
   initial
   begin
      forever #10 clk_in = !clk_in;
   end
   pcr_ctrl_model i_ctrl (.clk_in(clk_in), .hi_len_in(hi_len), .lo_len_in(lo_len), .pull_low_in(pull_low),
      .tie_in(tie), .dut_oe_in(s_oe), .fault_oe_in(f_oe), .sync_out(sync), .pin_out(pin));
   pcr_phase_current_readout i_dut (.clk_in(clk_in), .rst_in(rst_in), .sync_edge_aligned_in(sync),
      .overcurrent_in(oc), .differential_sense_input_in(mv), .duty_sample_pin_in(pin),
      .duty_sample_out_n_out(s_n), .duty_sample_oe_out(s_oe), .fault_out_n_out(f_n),
      .fault_oe_out(f_oe), .sample_channel_out(chan));
   // ====================
   // Helpers
   // ====================
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step
   function automatic logic pick(input int which);
      return which == 0 ? s_oe : (which == 1 ? f_oe : sync);
   endfunction : pick
   task automatic wait_for(input int which, input logic lvl, input int lim, output int n);
      n = 0;
      while (pick(which) !== lvl)
      begin
         step(1);
         n++;
         if (n > lim)
         begin
            chk("wait", 1, 0);
            wrap_up();
         end
      end
   endtask : wait_for
   // Released time of the next sample and its channel.
   task automatic meas(output int len, output logic ch);
      int n;
      wait_for(0, 1'b1, 4000, n);
      wait_for(0, 1'b0, 4000, n);
      ch = chan;
      wait_for(0, 1'b1, 1000, len);
   endtask : meas
   // ====================
   // Scenarios
   // ====================
   task automatic t_duty(input int v);
      int pml;
      int len;
      logic ch;
      logic ch_prev;
      mv = VIN_W'(v);
      pml = 200 - (2 * v) / 5;
      pml = pml < 100 ? 100 : (pml > 300 ? 300 : pml);
      repeat (2) meas(len, ch);
      repeat (2)
      begin
         ch_prev = ch;
         meas(len, ch);
         chk("released time", (ch ? hi_len : lo_len) * pml / 1000, len);
         chk("channel order", 1, ch != ch_prev);
      end
   endtask : t_duty
   task automatic t_fault();
      int n;
      int bad = 0;
      logic ch;
      mv = '0;
      oc = 1'b1;
      step(150);
      oc = 1'b0;
      step(10);
      chk("short overcurrent", 0, f_oe);
      oc = 1'b1;
      wait_for(1, 1'b1, 300, n);
      chk("debounce", 1, n >= 176 && n <= 186);
      repeat (2500)
      begin
         step(1);
         bad += (s_oe !== 1'b0);
      end
      chk("sample released", 0, bad);
      wait_for(2, !sync, 2000, n);
      step(20);
      pull_low = 1'b1;
      step(10);
      pull_low = 1'b0;
      step(10);
      chk("short clear", 1, f_oe);
      pull_low = 1'b1;
      step(25);
      pull_low = 1'b0;
      step(10);
      chk("fault cleared", 0, f_oe);
      wait_for(2, !sync, 2000, n);
      chk("no early fault", 0, f_oe);
      step(8);
      chk("fault back", 1, f_oe);
      oc = 1'b0;
      pull_low = 1'b1;
      step(36);
      pull_low = 1'b0;
      repeat (2) wait_for(2, !sync, 2000, n);
      repeat (2) meas(n, ch);
      chk("resumed", (ch ? hi_len : lo_len) * 200 / 1000, n);
      chk("stays clear", 0, f_oe);
   endtask : t_fault
   // Fault pin tied to the sample wire: the fault clears itself and returns.
   task automatic t_auto();
      int n;
      tie = 1'b1;
      oc = 1'b1;
      wait_for(1, 1'b1, 300, n);
      wait_for(1, 1'b0, 60, n);
      chk("auto clear", 1, n >= 25 && n <= 40);
      wait_for(1, 1'b1, 2000, n);
      oc = 1'b0;
      wait_for(1, 1'b0, 60, n);
      tie = 1'b0;
      repeat (2) wait_for(2, !sync, 2000, n);
      chk("auto stays clear", 0, f_oe);
   endtask : t_auto
   initial
   begin
      step(4);
      rst_in = 1'b0;
      chk("reset pins", 32'h5, {s_oe, s_n, f_oe, f_n});
      foreach (mvs[i]) t_duty(mvs[i]);
      t_fault();
      t_auto();
      wrap_up();
   end
endmodule : tb_pcr_phase_current_readout
